// File: telegram_receive_error_classifier.sv
/*
  Receive-side telegram checker and fault classifier with a single pending report.
  Assumes deframed telegrams and supervision events arrive synchronous to i_clock.
*/
module telegram_receive_error_classifier #(
  parameter int PROP_W = 16,  // width of component property word
  parameter int FNUM_W = 16   // width of remote fault number
) (
  input  wire logic                            i_clock,         // 20 MHz clock
  input  wire logic                            i_rst_b,         // async reset, active low
  input  wire logic                            i_rx_valid,      // one-cycle pulse: telegram done
  input  wire telegram_fault_pkg::rx_tel_t     i_rx_tel,        // received telegram summary
  input  wire telegram_fault_pkg::rx_entry_t   i_rx_entry,      // expected receive-list entry
  input  wire telegram_fault_pkg::link_evt_t   i_link_evt,      // supervision event pulses
  input  wire logic [7:0]                      i_link_comp,     // component for link events
  input  wire logic                            i_tx_req,        // send request pulse
  input  wire logic [7:0]                      i_tx_type,       // type of queued telegram
  input  wire logic [7:0]                      i_tx_list_type,  // type in send list
  input  wire logic [7:0]                      i_tx_comp,       // component of queued telegram
  input  wire logic                            i_prop_valid,    // property report pulse
  input  wire logic [PROP_W-1:0]               i_prop,          // reported properties
  input  wire logic [7:0]                      i_prop_comp,     // component of report
  input  wire logic                            i_remote_valid,  // remote fault pulse
  input  wire logic [FNUM_W-1:0]               i_remote_num,    // remote fault number
  input  wire logic                            i_remote_known,  // number decodable
  input  wire logic                            i_ack,           // acknowledge pending fault
  output logic                                 o_tx_go,         // send accepted, pulse
  output logic                                 o_tx_refuse,     // send refused, pulse
  output logic                                 o_fault,         // report pending
  output telegram_fault_pkg::fault_kind_t      o_fault_kind,    // class of report
  output logic [31:0]                          o_fault_value_readout // packed fault word
);

  ////////////////////////////////////////////////////////////////////////////
  // classification

  function automatic logic [7:0] rx_cause(input telegram_fault_pkg::rx_tel_t t,
                                          input telegram_fault_pkg::rx_entry_t e);
    logic [7:0] base;
    base = telegram_fault_pkg::CAUSE_NONE;
    if (!t.crc_ok)
      base = telegram_fault_pkg::CAUSE_CHECKSUM;
    // count is judged against the length byte; a list disagreement then falls to cause 04
    else if (t.byte_count < t.length_byte)
      base = telegram_fault_pkg::CAUSE_SHORT;
    else if (t.byte_count > t.length_byte)
      base = telegram_fault_pkg::CAUSE_LONG;
    else if (t.length_byte != e.length)
      base = telegram_fault_pkg::CAUSE_LEN_LIST;
    else if (t.tel_type != e.tel_type)
      base = telegram_fault_pkg::CAUSE_TYPE;
    else if (t.addr != e.addr)
      base = telegram_fault_pkg::CAUSE_ADDR;
    else if (t.error_bit)
      base = telegram_fault_pkg::CAUSE_ERROR_BIT;
    if (t.early) begin
      if (base != telegram_fault_pkg::CAUSE_NONE)
        base = base + telegram_fault_pkg::EARLY_OFFSET;
      else if (!t.life_bit)
        base = telegram_fault_pkg::CAUSE_EARLY_LIFE;
      else
        base = telegram_fault_pkg::CAUSE_EARLY;
    end
    // a bad header makes every field untrustworthy, so it overrides
    if (!t.header_ok)
      base = telegram_fault_pkg::CAUSE_HEADER;
    return base;
  endfunction

  function automatic logic [7:0] link_cause(input telegram_fault_pkg::link_evt_t v);
    logic [7:0] c;
    c = telegram_fault_pkg::CAUSE_NONE;
    if (v.no_cyclic)             c = telegram_fault_pkg::CAUSE_NO_CYCLIC;
    else if (v.rx_list_timeout)  c = telegram_fault_pkg::CAUSE_RX_LIST_TO;
    else if (v.tx_list_timeout)  c = telegram_fault_pkg::CAUSE_TX_LIST_TO;
    else if (v.to_cyclic_fail)   c = telegram_fault_pkg::CAUSE_TO_CYCLIC;
    else if (v.rx_buf_corrupt)   c = telegram_fault_pkg::CAUSE_RX_BUF;
    else if (v.tx_buf_corrupt_a) c = telegram_fault_pkg::CAUSE_TX_BUF_A;
    else if (v.tx_buf_corrupt_b) c = telegram_fault_pkg::CAUSE_TX_BUF_B;
    else if (v.runtime_late)     c = telegram_fault_pkg::CAUSE_RUNTIME;
    else if (v.char_data_late)   c = telegram_fault_pkg::CAUSE_CHAR_DATA;
    else if (v.sync_loss)        c = telegram_fault_pkg::CAUSE_SYNC_LOSS;
    return c;
  endfunction

  function automatic logic [31:0] pack_word(input logic [7:0] comp, input logic [7:0] cause);
    return {telegram_fault_pkg::WORD_UPPER, comp, cause};
  endfunction

  logic [7:0]                      rx_c;
  logic [7:0]                      lk_c;
  logic                            tx_bad;
  logic                            prop_bad;
  logic                            new_fault;
  logic [31:0]                     new_word;
  telegram_fault_pkg::fault_kind_t new_kind;

  ////////////////////////////////////////////////////////////////////////////
  // boot property capture

  logic [PROP_W-1:0] boot_prop;
  logic              boot_seen;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_prop <= '0;
      boot_seen <= 1'b0;
    end else if (i_prop_valid && !boot_seen) begin
      boot_prop <= i_prop;
      boot_seen <= 1'b1;
    end
  end

  always_comb begin
    rx_c     = i_rx_valid ? rx_cause(i_rx_tel, i_rx_entry) : telegram_fault_pkg::CAUSE_NONE;
    lk_c     = link_cause(i_link_evt);
    tx_bad   = i_tx_req && (i_tx_type != i_tx_list_type);
    prop_bad = i_prop_valid && boot_seen && (i_prop != boot_prop);
    new_fault = 1'b1;
    new_kind  = telegram_fault_pkg::KIND_TELEGRAM;
    // fixed priority when several events land in one cycle
    if (rx_c != telegram_fault_pkg::CAUSE_NONE)
      new_word = pack_word(i_rx_tel.comp, rx_c);
    else if (lk_c != telegram_fault_pkg::CAUSE_NONE)
      new_word = pack_word(i_link_comp, lk_c);
    else if (tx_bad)
      new_word = pack_word(i_tx_comp, telegram_fault_pkg::CAUSE_TX_TYPE);
    else if (prop_bad) begin
      new_word = {24'h000000, i_prop_comp};
      new_kind = telegram_fault_pkg::KIND_PROPERTY;
    end else if (i_remote_valid && !i_remote_known) begin
      new_word = 32'(i_remote_num);
      new_kind = telegram_fault_pkg::KIND_UNKNOWN;
    end else begin
      new_word  = '0;
      new_fault = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending report

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fault               <= 1'b0;
      o_fault_kind          <= telegram_fault_pkg::KIND_TELEGRAM;
      o_fault_value_readout <= '0;
    end else if (!o_fault || i_ack) begin
      // a fault arriving with the ack is kept rather than lost
      o_fault <= new_fault;
      if (new_fault) begin
        o_fault_kind          <= new_kind;
        o_fault_value_readout <= new_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // send gate

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_go     <= 1'b0;
      o_tx_refuse <= 1'b0;
    end else begin
      o_tx_go     <= i_tx_req && !tx_bad;
      o_tx_refuse <= tx_bad;
    end
  end

endmodule

// File: telegram_fault_pkg.sv
/*
  Shared types and constants for the telegram receive error classifier.
  Assumes a single 20 MHz clock domain; no software register access.
*/
package telegram_fault_pkg;

  localparam logic [7:0] CAUSE_CHECKSUM    = 8'h01;
  localparam logic [7:0] CAUSE_SHORT       = 8'h02;
  localparam logic [7:0] CAUSE_LONG        = 8'h03;
  localparam logic [7:0] CAUSE_LEN_LIST    = 8'h04;
  localparam logic [7:0] CAUSE_TYPE        = 8'h05;
  localparam logic [7:0] CAUSE_ADDR        = 8'h06;
  localparam logic [7:0] CAUSE_ERROR_BIT   = 8'h09;
  localparam logic [7:0] CAUSE_SYNC_LOSS   = 8'h0b;
  localparam logic [7:0] CAUSE_EARLY       = 8'h10;
  localparam logic [7:0] CAUSE_EARLY_LIFE  = 8'h1a;
  localparam logic [7:0] CAUSE_HEADER      = 8'h20;
  localparam logic [7:0] CAUSE_NO_CYCLIC   = 8'h21;
  localparam logic [7:0] CAUSE_RX_LIST_TO  = 8'h22;
  localparam logic [7:0] CAUSE_RX_BUF      = 8'h23;
  localparam logic [7:0] CAUSE_TX_LIST_TO  = 8'h40;
  localparam logic [7:0] CAUSE_TX_TYPE     = 8'h41;
  localparam logic [7:0] CAUSE_TX_BUF_A    = 8'h42;
  localparam logic [7:0] CAUSE_TX_BUF_B    = 8'h43;
  localparam logic [7:0] CAUSE_RUNTIME     = 8'h60;
  localparam logic [7:0] CAUSE_CHAR_DATA   = 8'h61;
  localparam logic [7:0] CAUSE_TO_CYCLIC   = 8'h62;
  localparam logic [7:0] CAUSE_NONE        = 8'h00;

  // early arrival adds this offset to the base cause
  localparam logic [7:0] EARLY_OFFSET      = 8'h10;

  localparam int         WORD_COMP_LSB     = 8;
  localparam logic [15:0] WORD_UPPER       = 16'h0000;

  // fault classes carried in the fault report
  typedef enum logic [1:0] {
    KIND_TELEGRAM,
    KIND_PROPERTY,
    KIND_UNKNOWN
  } fault_kind_t;

  // one received telegram after deframing
  typedef struct packed {
    logic [7:0] comp;        // component number of the sender
    logic [7:0] length_byte; // length byte carried in the telegram
    logic [7:0] byte_count;  // bytes actually received
    logic [7:0] tel_type;    // type field
    logic [7:0] addr;        // node address
    logic       crc_ok;      // checksum agrees
    logic       header_ok;   // header well formed
    logic       error_bit;   // supply-failed / error indication
    logic       life_bit;    // sign-of-life bit
    logic       early;       // arrived before scheduled instant
  } rx_tel_t;

  // receive-list entry expected for the next telegram
  typedef struct packed {
    logic [7:0] length;
    logic [7:0] tel_type;
    logic [7:0] addr;
  } rx_entry_t;

  // link supervision events, each a one-cycle pulse
  typedef struct packed {
    logic no_cyclic;
    logic rx_list_timeout;
    logic tx_list_timeout;
    logic to_cyclic_fail;
    logic rx_buf_corrupt;
    logic tx_buf_corrupt_a;
    logic tx_buf_corrupt_b;
    logic runtime_late;
    logic char_data_late;
    logic sync_loss;
  } link_evt_t;

endpackage

// File: sensor_partner.sv
/* far-end sensor module model handing deframed telegram summaries to the classifier.
   assumes the bench calls send() and that inputs move on the falling edge */
module sensor_partner (
  input  wire logic                   i_clock, // bench clock
  output logic                        o_valid, // telegram done pulse
  output telegram_fault_pkg::rx_tel_t o_tel    // telegram summary
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_valid = 1'b0;
    o_tel = '1;
  end
  // supply loss upstream travels as the error bit of the telegram
  task automatic send(input telegram_fault_pkg::rx_tel_t t);
    @(negedge i_clock);
    o_valid = 1'b1;
    o_tel = t;
    @(negedge i_clock);
    o_valid = 1'b0;
    // released lines show garbage, never a stale telegram
    o_tel = ~t;
  endtask
endmodule

// File: telegram_receive_error_classifier_assertions.sv
/* checker for the telegram fault classifier, bound to its top module.
   assumes one clock domain and an active-low asynchronous reset */
module classifier_checker (
  input wire logic                            i_clock,
  input wire logic                            i_rst_b,
  input wire logic                            i_rx_valid,
  input wire telegram_fault_pkg::rx_tel_t     i_rx_tel,
  input wire telegram_fault_pkg::link_evt_t   i_link_evt,
  input wire logic [7:0]                      i_link_comp,
  input wire logic                            i_tx_req,
  input wire logic [7:0]                      i_tx_type,
  input wire logic [7:0]                      i_tx_list_type,
  input wire logic                            i_ack,
  input wire logic                            o_tx_go,
  input wire logic                            o_tx_refuse,
  input wire logic                            o_fault,
  input wire telegram_fault_pkg::fault_kind_t o_fault_kind,
  input wire logic [31:0]                     o_fault_value_readout
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  telegram_fault_pkg::rx_tel_t last_tel;
  logic [7:0]                  last_comp;
  logic                        free;
  assign free = !o_fault || i_ack;
  always_ff @(posedge i_clock) begin
    last_tel <= i_rx_tel;
    last_comp <= i_link_comp;
  end
  ////////////////////////////////////////
  AST_WORD_UPPER: assert property (o_fault && o_fault_kind == telegram_fault_pkg::KIND_TELEGRAM
    |-> o_fault_value_readout[31:16] == 16'h0000) else $error("fault word upper half not zero");
  AST_TX_REFUSE: assert property (i_tx_req && i_tx_type != i_tx_list_type |=> o_tx_refuse && !o_tx_go)
    else $error("mismatched send not refused");
  AST_TX_GO: assert property (i_tx_req && i_tx_type == i_tx_list_type |=> o_tx_go && !o_tx_refuse)
    else $error("matching send not accepted");
  AST_HOLD: assert property (o_fault && !i_ack |=> o_fault && $stable(o_fault_value_readout))
    else $error("pending report changed without acknowledge");
  AST_EARLY_BIT: assert property (i_rx_valid && free && i_rx_tel.header_ok && (i_rx_tel.early || !i_rx_tel.crc_ok)
    |=> o_fault && o_fault_value_readout[4] == last_tel.early && o_fault_value_readout[15:8] == last_tel.comp)
    else $error("early offset or component wrong");
  AST_CRC: assert property (i_rx_valid && free && i_rx_tel.header_ok && !i_rx_tel.crc_ok
    |=> o_fault_value_readout[7:0] == (last_tel.early ? 8'h11 : 8'h01)) else $error("checksum cause wrong");
  AST_HEADER: assert property (i_rx_valid && free && !i_rx_tel.header_ok
    |=> o_fault_value_readout[7:0] == 8'h20) else $error("header cause wrong");
  AST_NO_CYCLIC: assert property (i_link_evt.no_cyclic && !i_rx_valid && free
    |=> o_fault_value_readout == {16'h0000, last_comp, 8'h21}) else $error("missing cyclic cause wrong");
endmodule
bind telegram_receive_error_classifier classifier_checker classifier_checker_i (.*);

// File: telegram_receive_error_classifier_bench.sv
/* self-checking bench for the telegram fault classifier.
   assumes the partner model feeds telegrams and the bench drives the rest */
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module telegram_receive_error_classifier_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam telegram_fault_pkg::rx_tel_t GOOD = '{8'h05, 8'h08, 8'h08, 8'h11, 8'h22, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic i_clock, i_rst_b, i_rx_valid, i_tx_req, i_prop_valid, i_remote_valid, i_remote_known, i_ack;
  logic o_tx_go, o_tx_refuse, o_fault;
  telegram_fault_pkg::rx_tel_t     i_rx_tel, t;
  telegram_fault_pkg::rx_entry_t   i_rx_entry;
  telegram_fault_pkg::link_evt_t   i_link_evt;
  telegram_fault_pkg::fault_kind_t o_fault_kind;
  logic [7:0]  i_link_comp, i_tx_type, i_tx_list_type, i_tx_comp, i_prop_comp, x;
  logic [15:0] i_prop, i_remote_num;
  logic [31:0] o_fault_value_readout;
  int          err_total = 0, checks = 0, cyc = 0;
  sensor_partner sensor_partner_i (.i_clock(i_clock), .o_valid(i_rx_valid), .o_tel(i_rx_tel));
  telegram_receive_error_classifier telegram_receive_error_classifier_i (.*);
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_clock);
    s = 1'b0;
    @(negedge i_clock);
  endtask
  task automatic expect_word(input telegram_fault_pkg::fault_kind_t k, input logic [31:0] w);
    `CHK(o_fault, 1'b1)
    `CHK(o_fault_kind, k)
    `CHK(o_fault_value_readout, w)
    i_ack = 1'b1;
    @(negedge i_clock);
    i_ack = 1'b0;
    `CHK(o_fault, 1'b0)
    `CHK(o_fault_value_readout, w)
  endtask
  ////////////////////////////////////////
  task automatic rx_table();
    logic [7:0] base [10] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h09, 8'h00, 8'h00, 8'h20, 8'h04};
    for (int e = 0; e < 2; e++) for (int k = 0; k < 10; k++) begin
      t = GOOD;
      t.comp = 8'(k + 16 * e);
      t.early = e[0];
      case (k)
        0: t.crc_ok = 1'b0;
        1: t.byte_count = 8'h07;
        2: t.byte_count = 8'h09;
        3: t.tel_type = 8'h12;
        4: t.addr = 8'h23;
        5: t.error_bit = 1'b1;
        7: t.life_bit = 1'b0;
        8: t.header_ok = 1'b0;
        9: {t.length_byte, t.byte_count} = {8'h09, 8'h09};
        default: ;
      endcase
      x = (k == 8) ? 8'h20 : (k == 7 && e == 1) ? 8'h1a : base[k] + (e == 1 ? 8'h10 : 8'h00);
      sensor_partner_i.send(t);
      if (x == 8'h00) `CHK(o_fault, 1'b0)
      else expect_word(telegram_fault_pkg::KIND_TELEGRAM, {16'h0000, t.comp, x});
    end
  endtask
  task automatic latch_first();
    t = GOOD;
    t.crc_ok = 1'b0;
    sensor_partner_i.send(t);
    t.crc_ok = 1'b1;
    t.addr = 8'h00;
    sensor_partner_i.send(t);
    `CHK(o_fault_value_readout, 32'h00000501)
    // acknowledge and a new event in one cycle: the new one must win
    i_ack = 1'b1;
    i_link_comp = 8'h0c;
    i_link_evt.sync_loss = 1'b1;
    @(negedge i_clock);
    i_ack = 1'b0;
    i_link_evt = '0;
    expect_word(telegram_fault_pkg::KIND_TELEGRAM, 32'h00000c0b);
  endtask
  task automatic link_events();
    logic [7:0] code [10] = '{8'h21, 8'h22, 8'h40, 8'h62, 8'h23, 8'h42, 8'h43, 8'h60, 8'h61, 8'h0b};
    for (int i = 0; i < 10; i++) begin
      i_link_comp = 8'(i + 1);
      i_link_evt = 10'h200 >> i;
      @(negedge i_clock);
      i_link_evt = '0;
      expect_word(telegram_fault_pkg::KIND_TELEGRAM, {16'h0000, i_link_comp, code[i]});
    end
  endtask
  task automatic tx_and_props();
    i_tx_comp = 8'h0d;
    i_tx_req = 1'b1;
    @(negedge i_clock);
    i_tx_req = 1'b0;
    `CHK({o_tx_go, o_tx_refuse, o_fault}, 3'b100)
    i_tx_type = 8'h32;
    i_tx_req = 1'b1;
    @(negedge i_clock);
    i_tx_req = 1'b0;
    `CHK({o_tx_go, o_tx_refuse}, 2'b01)
    expect_word(telegram_fault_pkg::KIND_TELEGRAM, 32'h00000d41);
    pulse(i_prop_valid);
    pulse(i_prop_valid);
    `CHK(o_fault, 1'b0)
    i_prop = 16'h1235;
    pulse(i_prop_valid);
    expect_word(telegram_fault_pkg::KIND_PROPERTY, 32'h00000007);
    pulse(i_remote_valid);
    `CHK(o_fault, 1'b0)
    i_remote_known = 1'b0;
    pulse(i_remote_valid);
    expect_word(telegram_fault_pkg::KIND_UNKNOWN, 32'h0000beef);
  endtask
  ////////////////////////////////////////
  initial begin
    {i_rst_b, i_tx_req, i_prop_valid, i_remote_valid, i_ack} = '0;
    i_rx_entry = '{8'h08, 8'h11, 8'h22};
    i_link_evt = '0;
    {i_link_comp, i_tx_type, i_tx_list_type, i_tx_comp} = {8'h00, 8'h31, 8'h31, 8'h00};
    {i_prop_comp, i_prop, i_remote_num, i_remote_known} = {8'h07, 16'h1234, 16'hbeef, 1'b1};
    repeat (5) @(negedge i_clock);
    i_rst_b = 1'b1;
    `CHK({o_fault, o_tx_go, o_tx_refuse, o_fault_value_readout}, 35'h0)
    rx_table();
    latch_first();
    link_events();
    tx_and_props();
    give_verdict();
  end
endmodule
